// ---- sad_sequencer.v ----
// Operation
// RL1 - decode 5-bit select; references, off code
// RL2 - reserved or unused codes give undefined results
// RL3 - code 11010 routes temperature sensor
// RL4 - code 11011 routes internal bandgap
// RL5 - four selectable conversion clock sources
// RL6 - programmable divider forms conversion clock
// RL7 - alternate clock unusable in stop modes
// RL8 - hardware trigger pulse starts conversion
// RL9 - trigger honoured in run, wait, stop3
// RL10 - right-justified result, 12/10/8 bits
// RL11 - single or continuous; single returns idle
// RL12 - completion sets flag and interrupt
// RL13 - automatic compare less-than or greater-equal
// RL14 - short/long sample, speed versus power
// RL15 - operate in wait/stop3 with running clock
// RL16 - software: long sample, slow clock for temperature
// RL17 - control write aborts, restarts unless off (code restarts only under software trigger and outside stop2)
// RL18 - control write or result read clears flag
// RL19 - active flag tracks conversion in progress
// RL20 - result held until next completion
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
`include "sad_regs.vh"

module sad_sequencer (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [1:0]  pwr_mode,
  input  wire        hw_trigger_in,
  input  wire        local_async_clock,
  input  wire        alternate_clock_in,
  input  wire        cmp_in,
  output reg  [4:0]  mux_select,
  output reg         temp_sense_en,
  output reg         bandgap_en,
  output reg         refh_en,
  output reg         refl_en,
  output reg         conv_power_on,
  output reg         sample_en,
  output reg  [11:0] sar_trial,
  output reg         low_power_mode,
  output reg         long_sample,
  output wire        conv_irq
);

  localparam ST_IDLE   = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONV   = 2'h2;

  reg  [4:0]  sel_reg;
  reg         cont_reg;
  reg         ien_reg;
  reg         done_reg;
  reg         cmpge_reg;
  reg         cmpen_reg;
  reg         hwt_reg;
  reg         active_reg;
  reg  [7:0]  cfg_reg;
  reg  [11:0] cmpval_reg;
  reg  [11:0] result_reg;
  reg         ack_reg;
  reg  [1:0]  state_reg;
  reg  [4:0]  smp_cnt_reg;
  reg  [3:0]  bit_reg;
  reg  [1:0]  settle_reg;
  reg  [11:0] sar_reg;
  reg  [1:0]  pm_s1_reg;
  reg  [1:0]  pm_s2_reg;
  reg  [2:0]  hwt_sync_reg;
  reg  [1:0]  cmp_sync_reg;

  wire        conv_tick;
  wire        req;
  wire        wr_ctrl1;
  wire        rd_result;
  wire        hw_edge;
  wire        trig_ok;
  wire        start;
  wire        finish;
  wire        cmp_true;
  wire        done_set;
  wire [11:0] sar_final;
  wire [11:0] fmt_value;
  wire [11:0] bit_mask;

  // one result width decoder serves both compare and result storage
  function [11:0] fmt_result;
    input [11:0] raw;
    input [1:0]  mode;
    begin
      case (mode)
        `SAD_MODE_12: fmt_result = raw;
        `SAD_MODE_10: fmt_result = {2'h0, raw[11:2]};
        default:      fmt_result = {4'h0, raw[11:4]};
      endcase
    end
  endfunction

  sad_clkgen u_clkgen (
    .clk_sys            (clk_sys),
    .rst                (rst),
    .clk_src            (cfg_reg[`SAD_SRC_MSB:`SAD_SRC_LSB]), // [RL5]
    .div_sel            (cfg_reg[`SAD_DIV_MSB:`SAD_DIV_LSB]),
    .pwr_mode           (pm_s2_reg),
    .local_async_clock  (local_async_clock),
    .alternate_clock_in (alternate_clock_in),
    .conv_tick          (conv_tick)
  );

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pm_s1_reg    <= `SAD_PM_RUN;
      pm_s2_reg    <= `SAD_PM_RUN;
      hwt_sync_reg <= 3'h0;
      cmp_sync_reg <= 2'h0;
    end else begin
      pm_s1_reg    <= pwr_mode;
      pm_s2_reg    <= pm_s1_reg;
      hwt_sync_reg <= {hwt_sync_reg[1:0], hw_trigger_in};
      cmp_sync_reg <= {cmp_sync_reg[0], cmp_in};
    end
  end

  // bus slave: one wait cycle, answer at the second edge
  assign req             = (avs_read | avs_write) & ~ack_reg;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_ctrl1  = avs_write & ack_reg & avs_byteenable[0]
                   & (avs_address == `SAD_OFS_CTRL1);
  assign rd_result = avs_read & ack_reg & (avs_address == `SAD_OFS_RESULT);

  assign hw_edge  = hwt_sync_reg[1] & ~hwt_sync_reg[2];
  assign trig_ok  = (pm_s2_reg != `SAD_PM_STOP2); // [RL9]
  assign start    = hwt_reg & hw_edge & trig_ok & ~active_reg
                  & (sel_reg != `SAD_CODE_OFF); // [RL8]

  assign bit_mask  = 12'h800 >> bit_reg;
  assign sar_final = cmp_sync_reg[1] ? sar_reg : (sar_reg & ~bit_mask);
  assign finish    = (state_reg == ST_CONV) & conv_tick & (settle_reg == 2'h0)
                   & (bit_reg == `SAD_RES_BITS);
  assign fmt_value = fmt_result(sar_final, cfg_reg[`SAD_MODE_MSB:`SAD_MODE_LSB]);
  assign cmp_true  = cmpge_reg ? (fmt_value >= cmpval_reg)
                               : (fmt_value < cmpval_reg); // [RL13]
  // a control write aborts a conversion that would finish at the same edge
  assign done_set  = finish & ~wr_ctrl1 & (~cmpen_reg | cmp_true);
  assign conv_irq  = done_reg & ien_reg; // [RL12]

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req & avs_read) begin
        case (avs_address)
          `SAD_OFS_CTRL1:  avs_readdata <= {24'h0, done_reg, ien_reg, cont_reg, sel_reg};
          `SAD_OFS_CTRL2:  avs_readdata <= {24'h0, active_reg, hwt_reg, cmpen_reg,
                                            cmpge_reg, 4'h0};
          `SAD_OFS_RESULT: avs_readdata <= {20'h0, result_reg};
          `SAD_OFS_CMPVAL: avs_readdata <= {20'h0, cmpval_reg};
          `SAD_OFS_CFG:    avs_readdata <= {24'h0, cfg_reg};
          default:         avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_reg    <= `SAD_SEL_RST;
      cont_reg   <= 1'b0;
      ien_reg    <= 1'b0;
      cmpge_reg  <= 1'b0;
      cmpen_reg  <= 1'b0;
      hwt_reg    <= 1'b0;
      cfg_reg    <= `SAD_CFG_RST;
      cmpval_reg <= `SAD_CMP_RST;
    end else if (avs_write & ack_reg) begin
      case (avs_address)
        `SAD_OFS_CTRL1: begin
          if (avs_byteenable[0]) begin
            sel_reg  <= avs_writedata[`SAD_SEL_MSB:`SAD_SEL_LSB];
            cont_reg <= avs_writedata[`SAD_CONT_BIT];
            ien_reg  <= avs_writedata[`SAD_IEN_BIT];
          end
        end
        `SAD_OFS_CTRL2: begin
          if (avs_byteenable[0]) begin
            cmpge_reg <= avs_writedata[`SAD_CMPGE_BIT];
            cmpen_reg <= avs_writedata[`SAD_CMPEN_BIT];
            hwt_reg   <= avs_writedata[`SAD_HWT_BIT];
          end
        end
        `SAD_OFS_CMPVAL: begin
          if (avs_byteenable[0])
            cmpval_reg[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1])
            cmpval_reg[11:8] <= avs_writedata[11:8];
        end
        `SAD_OFS_CFG: begin
          if (avs_byteenable[0])
            cfg_reg <= avs_writedata[7:0]; // [RL14]
        end
        default: begin
        end
      endcase
    end
  end

  // done flag: a completion in a result-read clearing cycle wins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_reg   <= 1'b0;
      result_reg <= 12'h000;
    end else begin
      if (done_set) begin
        done_reg   <= 1'b1; // [RL12]
        result_reg <= fmt_value; // [RL10] [RL20] [RL2]
      end else if (wr_ctrl1 | rd_result) begin
        done_reg <= 1'b0; // [RL18]
      end
    end
  end

  // conversion sequencer
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      active_reg  <= 1'b0;
      smp_cnt_reg <= 5'h00;
      bit_reg     <= 4'h0;
      settle_reg  <= 2'h0;
      sar_reg     <= 12'h000;
    end else begin
      if (settle_reg != 2'h0)
        settle_reg <= settle_reg - 2'h1;
      if (wr_ctrl1) begin
        // abort, then restart under software trigger unless the off code or stop2
        state_reg  <= ST_IDLE; // [RL17]
        active_reg <= 1'b0; // [RL19]
        if (~hwt_reg && avs_writedata[`SAD_SEL_MSB:`SAD_SEL_LSB] != `SAD_CODE_OFF
            && pm_s2_reg != `SAD_PM_STOP2) begin
          state_reg   <= ST_SAMPLE; // [RL17]
          active_reg  <= 1'b1; // [RL19]
          smp_cnt_reg <= 5'h00;
        end
      end else if (start) begin
        state_reg   <= ST_SAMPLE;
        active_reg  <= 1'b1; // [RL19]
        smp_cnt_reg <= 5'h00;
      end else begin
        case (state_reg)
          ST_SAMPLE: begin
            if (conv_tick) begin
              smp_cnt_reg <= smp_cnt_reg + 5'h01;
              if (smp_cnt_reg == (cfg_reg[`SAD_LSMP_BIT] ? `SAD_SMP_LONG
                                                         : `SAD_SMP_SHORT)) begin
                state_reg  <= ST_CONV; // [RL14]
                bit_reg    <= 4'h0;
                sar_reg    <= 12'h800;
                settle_reg <= `SAD_SETTLE;
              end
            end
          end
          ST_CONV: begin
            if (conv_tick && settle_reg == 2'h0) begin
              if (bit_reg == `SAD_RES_BITS) begin
                sar_reg <= sar_final;
                if (cont_reg && sel_reg != `SAD_CODE_OFF) begin
                  state_reg   <= ST_SAMPLE; // [RL11]
                  smp_cnt_reg <= 5'h00;
                end else begin
                  state_reg  <= ST_IDLE; // [RL11]
                  active_reg <= 1'b0; // [RL19]
                end
              end else begin
                sar_reg    <= sar_final | (bit_mask >> 1);
                bit_reg    <= bit_reg + 4'h1;
                settle_reg <= `SAD_SETTLE;
              end
            end
          end
          default: begin
            state_reg  <= ST_IDLE;
            active_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // analog front end control
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mux_select     <= `SAD_CODE_OFF;
      temp_sense_en  <= 1'b0;
      bandgap_en     <= 1'b0;
      refh_en        <= 1'b0;
      refl_en        <= 1'b0;
      conv_power_on  <= 1'b0;
      sample_en      <= 1'b0;
      sar_trial      <= 12'h000;
      low_power_mode <= 1'b0;
      long_sample    <= 1'b0;
    end else begin
      mux_select     <= sel_reg; // [RL1]
      temp_sense_en  <= (sel_reg == `SAD_CODE_TEMP); // [RL3]
      bandgap_en     <= (sel_reg == `SAD_CODE_BGAP); // [RL4]
      refh_en        <= (sel_reg == `SAD_CODE_REFH); // [RL1]
      refl_en        <= (sel_reg == `SAD_CODE_REFL); // [RL1]
      conv_power_on  <= (sel_reg != `SAD_CODE_OFF) & (state_reg != ST_IDLE); // [RL1]
      sample_en      <= (state_reg == ST_SAMPLE);
      sar_trial      <= sar_reg;
      low_power_mode <= cfg_reg[`SAD_LPWR_BIT]; // [RL14]
      long_sample    <= cfg_reg[`SAD_LSMP_BIT];
    end
  end

endmodule

// ---- sad_regs.vh ----
`ifndef SAD_REGS_VH
`define SAD_REGS_VH

// register byte offsets
`define SAD_OFS_CTRL1      5'h00
`define SAD_OFS_CTRL2      5'h04
`define SAD_OFS_RESULT     5'h08
`define SAD_OFS_CMPVAL     5'h0C
`define SAD_OFS_CFG        5'h10

// first control register fields
`define SAD_SEL_MSB        4
`define SAD_SEL_LSB        0
`define SAD_CONT_BIT       5
`define SAD_IEN_BIT        6
`define SAD_DONE_BIT       7
// second control register fields
`define SAD_CMPGE_BIT      4
`define SAD_CMPEN_BIT      5
`define SAD_HWT_BIT        6
`define SAD_ACT_BIT        7
// configuration fields
`define SAD_SRC_MSB        1
`define SAD_SRC_LSB        0
`define SAD_DIV_MSB        3
`define SAD_DIV_LSB        2
`define SAD_MODE_MSB       5
`define SAD_MODE_LSB       4
`define SAD_LSMP_BIT       6
`define SAD_LPWR_BIT       7

// reset values
`define SAD_SEL_RST        5'h1F
`define SAD_CFG_RST        8'h00
`define SAD_CMP_RST        12'h000

// input select codes
`define SAD_CODE_RSVD      5'h1C
`define SAD_CODE_TEMP      5'h1A
`define SAD_CODE_BGAP      5'h1B
`define SAD_CODE_REFH      5'h1D
`define SAD_CODE_REFL      5'h1E
`define SAD_CODE_OFF       5'h1F

// conversion clock sources
`define SAD_SRC_BUS        2'h0
`define SAD_SRC_BUS2       2'h1
`define SAD_SRC_ALT        2'h2
`define SAD_SRC_ASYNC      2'h3

// result width modes
`define SAD_MODE_8         2'h0
`define SAD_MODE_12        2'h1
`define SAD_MODE_10        2'h2

// system power modes
`define SAD_PM_RUN         2'h0
`define SAD_PM_WAIT        2'h1
`define SAD_PM_STOP3       2'h2
`define SAD_PM_STOP2       2'h3

// timing counts in conversion clock ticks / system cycles
`define SAD_SMP_SHORT      5'h03
`define SAD_SMP_LONG       5'h13
`define SAD_SETTLE         2'h3
`define SAD_RES_BITS       4'hB

`endif

// ---- sad_clkgen.v ----
`timescale 1ns/1ns
`include "sad_regs.vh"

module sad_clkgen (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire [1:0] clk_src,
  input  wire [1:0] div_sel,
  input  wire [1:0] pwr_mode,
  input  wire       local_async_clock,
  input  wire       alternate_clock_in,
  output reg        conv_tick
);

  reg  [2:0] async_sync_reg;
  reg  [2:0] alt_sync_reg;
  reg        half_reg;
  reg  [2:0] div_cnt_reg;
  reg        src_pulse;
  wire [2:0] div_max;

  assign div_max = (3'h1 << div_sel) - 3'h1;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      async_sync_reg <= 3'h0;
      alt_sync_reg   <= 3'h0;
      half_reg       <= 1'b0;
    end else begin
      async_sync_reg <= {async_sync_reg[1:0], local_async_clock};
      alt_sync_reg   <= {alt_sync_reg[1:0], alternate_clock_in};
      half_reg       <= ~half_reg;
    end
  end

  // bus clocks halt in both stop modes; stop2 also stops the asynchronous clock
  always @* begin
    src_pulse = 1'b0;
    case (clk_src)
      `SAD_SRC_BUS:   src_pulse = 1'b1;
      `SAD_SRC_BUS2:  src_pulse = half_reg;
      `SAD_SRC_ALT:   src_pulse = alt_sync_reg[1] & ~alt_sync_reg[2];
      `SAD_SRC_ASYNC: src_pulse = async_sync_reg[1] & ~async_sync_reg[2];
      default:        src_pulse = 1'b0;
    endcase
    if (pwr_mode == `SAD_PM_STOP2)
      src_pulse = 1'b0;
    if (pwr_mode == `SAD_PM_STOP3 && clk_src != `SAD_SRC_ASYNC) // [RL7] [RL15]
      src_pulse = 1'b0;
  end

  always @(posedge clk_sys or posedge rst) begin // [RL6]
    if (rst) begin
      div_cnt_reg <= 3'h0;
      conv_tick   <= 1'b0;
    end else begin
      conv_tick <= 1'b0;
      if (src_pulse) begin
        if (div_cnt_reg >= div_max) begin
          div_cnt_reg <= 3'h0;
          conv_tick   <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 3'h1;
        end
      end
    end
  end

endmodule

// ---- sad_analog.sv ----
`timescale 1ns/1ns
module sad_analog (
  input  wire        clk_sys,
  input  wire [4:0]  mux_select,
  input  wire        conv_power_on,
  input  wire        sample_en,
  input  wire [11:0] sar_trial,
  output wire        cmp_in
);
  reg [11:0] level [0:31];
  reg [11:0] held = 12'h000;
  reg        tog  = 1'b0;
  always @(posedge clk_sys) begin
    tog <= ~tog;
    if (sample_en) begin
      case (mux_select)
        5'h1D:   held <= 12'hFFF;
        5'h1E:   held <= 12'h000;
        default: held <= level[mux_select];
      endcase
    end
  end
  // an unpowered comparator gives no steady answer
  assign cmp_in = conv_power_on ? (held >= sar_trial) : tog;
endmodule

// ---- sad_sequencer_chk.sv ----
`timescale 1ns/1ns
module sad_checker (
  input wire        clk_sys,
  input wire        rst,
  input wire [4:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest,
  input wire [1:0]  pwr_mode,
  input wire [4:0]  mux_select,
  input wire        temp_sense_en,
  input wire        bandgap_en,
  input wire        refh_en,
  input wire        refl_en,
  input wire        conv_power_on,
  input wire        sample_en,
  input wire [11:0] sar_trial,
  input wire        long_sample,
  input wire        conv_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire acc = !avs_waitrequest;
  property p_refh; (mux_select == 5'h1D) [*2] |-> refh_en && !refl_en; endproperty
  a_refh: assert property (p_refh) else $error("high reference decode wrong");
  property p_off; (mux_select == 5'h1F) [*2] |-> !conv_power_on && !refl_en; endproperty
  a_off: assert property (p_off) else $error("converter powered while off");
  property p_temp; (mux_select == 5'h1A) [*2] |-> temp_sense_en && !bandgap_en; endproperty
  a_temp: assert property (p_temp) else $error("temperature decode wrong");
  property p_bgap; (mux_select == 5'h1B) [*2] |-> bandgap_en && !temp_sense_en; endproperty
  a_bgap: assert property (p_bgap) else $error("bandgap decode wrong");
  property p_wclr; avs_write && acc && avs_address == 5'h00 |=> !conv_irq; endproperty
  a_wclr: assert property (p_wclr) else $error("irq after control write");
  property p_rclr; avs_read && acc && avs_address == 5'h08 |=> !conv_irq; endproperty
  a_rclr: assert property (p_rclr) else $error("irq after result read");
  property p_smp;
    $rose(sample_en) && long_sample |-> (sample_en || !conv_power_on) [*8];
  endproperty
  a_smp: assert property (p_smp) else $error("long sample too short");
  property p_stop;
    (pwr_mode == 2'h3) [*5] ##1 (pwr_mode == 2'h3 && !avs_write) |=> $stable(sar_trial);
  endproperty
  a_stop: assert property (p_stop) else $error("trial moved in stop2");
  c_irq: cover property ($rose(conv_irq));
  c_long: cover property ($rose(sample_en) && long_sample);
  c_stop3: cover property (sample_en && pwr_mode == 2'h2);
endmodule

bind sad_sequencer sad_checker u_chk (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
  .avs_waitrequest, .pwr_mode, .mux_select, .temp_sense_en, .bandgap_en, .refh_en,
  .refl_en, .conv_power_on, .sample_en, .sar_trial, .long_sample, .conv_irq);

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  reg         clk_sys = 1'b0;
  reg         rst = 1'b1;
  reg  [4:0]  avs_address = 5'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [3:0]  avs_byteenable = 4'hF;
  reg  [1:0]  pwr_mode = 2'h0;
  reg         hw_trigger_in = 1'b0;
  reg         local_async_clock = 1'b0;
  reg         alternate_clock_in = 1'b0;
  reg  [2:0]  sub = 3'h0;
  reg  [31:0] q;
  reg  [31:0] seed = 32'h7AE2;
  reg  [11:0] ev;
  wire [31:0] avs_readdata;
  wire [11:0] sar_trial;
  wire [4:0]  mux_select;
  wire        avs_waitrequest, cmp_in, temp_sense_en, bandgap_en, refh_en, refl_en;
  wire        conv_power_on, sample_en, low_power_mode, long_sample, conv_irq;
  integer     miscompares = 0;
  integer     n_checks = 0;
  integer     i;
  localparam [24:0] CODES = {5'h1B, 5'h1A, 5'h1D, 5'h1E, 5'h03};
  localparam [39:0] CFGS  = {8'h5D, 8'h5D, 8'h22, 8'h87, 8'h10};

  sad_sequencer uut (.*);
  sad_analog    ana (.*);

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    sub <= sub + 3'h1;
    local_async_clock <= sub[1];
    alternate_clock_in <= sub[2];
  end

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask

  task tmo;
    begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // request held until the rising edge at which waitrequest is low
  task bus(input rd, input [4:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      k = 0;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) begin
        k = k + 1;
        if (k > 20) tmo;
        @(posedge clk_sys);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(negedge clk_sys);
    end
  endtask

  task wr(input [4:0] a, input [15:0] d);
    bus(1'b0, a, {16'h0, d});
  endtask

  task rd(input [4:0] a);
    bus(1'b1, a, 32'h0);
  endtask

  task poll(input [4:0] a, input integer b, input x);
    integer k;
    begin
      k = 0;
      rd(a);
      while (q[b] !== x) begin
        k = k + 1;
        if (k == 600) tmo;
        rd(a);
      end
    end
  endtask

  task run(input [4:0] c, input [7:0] f, input [11:0] lv);
    begin
      ana.level[c] = lv;
      wr(5'h10, {8'h00, f});
      wr(5'h00, {8'h00, 3'b010, c});
      poll(5'h04, 7, 1'b0);
      chk("irq", 1, conv_irq);
      chk("long", f[6], long_sample);
      chk("lowpwr", f[7], low_power_mode);
      rd(5'h08);
      ev = (c == 5'h1D) ? 12'hFFF : (c == 5'h1E) ? 12'h000 : lv;
      ev = (f[5:4] == 2'h0) ? ev >> 4 : (f[5:4] == 2'h2) ? ev >> 2 : ev;
      chk("result", ev, q);
      chk("irq clear", 0, conv_irq);
    end
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(5'h00);
    chk("sel reset", 32'h1F, q);
    rd(5'h10);
    chk("cfg reset", 0, q);
    rd(5'h14);
    chk("unmapped", 0, q);
    $display("reset test done");
    for (i = 0; i < 5; i = i + 1) begin
      seed = lfsr(seed);
      run(CODES[24-5*i -: 5], CFGS[39-8*i -: 8], seed[11:0]);
    end
    ana.level[3] = ~seed[11:0];
    rd(5'h08);
    chk("held", {20'h0, seed[11:0]}, q);
    $display("channel test done");
    ana.level[5] = 12'hE5D;
    wr(5'h10, 16'h0050);
    wr(5'h00, 16'h0003);
    rd(5'h04);
    chk("active", 1, q[7]);
    wr(5'h00, 16'h0005);
    poll(5'h04, 7, 1'b0);
    rd(5'h08);
    chk("abort", 32'hE5D, q);
    $display("abort test done");
    wr(5'h00, 16'h0063);
    poll(5'h00, 7, 1'b1);
    rd(5'h08);
    poll(5'h00, 7, 1'b1);
    chk("cont irq", 1, conv_irq);
    wr(5'h00, 16'h001F);
    poll(5'h04, 7, 1'b0);
    chk("off", 0, conv_power_on);
    $display("continuous test done");
    wr(5'h0C, 16'h0800);
    for (i = 0; i < 3; i = i + 1) begin
      ana.level[3] = (i == 0) ? 12'h900 : 12'h700;
      wr(5'h04, (i == 2) ? 16'h0020 : 16'h0030);
      wr(5'h00, 16'h0003);
      poll(5'h04, 7, 1'b0);
      rd(5'h00);
      chk("cmp done", i != 1, q[7]);
      rd(5'h08);
      chk("cmp result", (i == 2) ? 32'h700 : 32'h900, q);
    end
    $display("compare test done");
    wr(5'h04, 16'h0000);
    wr(5'h10, 16'h0012);
    @(posedge clk_sys);
    pwr_mode <= 2'h2;
    wr(5'h00, 16'h0003);
    repeat (40) rd(5'h04);
    chk("alt in stop3", 1, q[7]);
    @(posedge clk_sys);
    pwr_mode <= 2'h0;
    poll(5'h04, 7, 1'b0);
    $display("stop3 clock test done");
    wr(5'h10, 16'h0013);
    wr(5'h04, 16'h0040);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk_sys);
      pwr_mode <= i[1:0];
      wr(5'h00, 16'h0003);
      rd(5'h04);
      chk("armed idle", 0, q[7]);
      @(posedge clk_sys);
      hw_trigger_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      hw_trigger_in <= 1'b0;
      if (i == 3) repeat (40) rd(5'h04);
      else poll(5'h04, 7, 1'b0);
      rd(5'h00);
      chk("hw done", i != 3, q[7]);
    end
    $display("trigger test done");
    report_and_stop;
  end
endmodule
